//--- blit_clip_address_gen.v
// blit_clip_address_gen.v: clip, reject and address walk for rectangle blits
// assumes a command streamer on the same clock and a memory side that may stall
// Function
// - clip top-left inclusive, bottom-right exclusive
// - trivial reject before any memory access
// - negative source and destination coordinates legal
// - negative source start shifts destination start
// - empty rectangle after adjustment is rejected
// - pitch bytes if linear, dwords if tiled
// - destination address base plus y*pitch plus x*bpp
// - source address base plus y*pitch plus x*bpp
// - same base, src x smaller: right to left
// - same base, src y smaller: bottom to top
// - direction chosen without any overlap check
// - decoded fields internal, clip state kept
`timescale 1ns/10ps
`include "blit_clip_map.vh"

// ----------------------------------------------------------------
// fifo of address pairs toward memory
// ----------------------------------------------------------------
module addr_fifo #(
    parameter WIDTH = 64,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rstn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    // full and empty both come from the occupancy count
    // one extra count bit tells a full fifo from an empty one
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointers wrap since depth is a power of two
    always @(posedge clk) begin
        if (!rstn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule // addr_fifo

// ----------------------------------------------------------------
// top: command in, pixel address pairs out
// ----------------------------------------------------------------
module blit_clip_address_gen #(
    parameter CW = 16,
    parameter AW = 32
) (
    input wire clk,
    input wire rstn,
    input wire cmd_valid,
    output reg cmd_ready,
    input wire [1:0] cmd_op,
    input wire clip_en,
    input wire signed [CW-1:0] dest_left,
    input wire signed [CW-1:0] dest_top,
    input wire signed [CW-1:0] dest_right,
    input wire signed [CW-1:0] dest_bottom,
    input wire signed [CW-1:0] src_left,
    input wire signed [CW-1:0] src_top,
    input wire [AW-1:0] dest_base,
    input wire [AW-1:0] src_base,
    input wire [CW-1:0] dest_pitch,
    input wire [CW-1:0] src_pitch,
    input wire [1:0] dest_tiling,
    input wire [1:0] src_tiling,
    input wire [2:0] bytes_per_pixel,
    output reg mem_valid,
    input wire mem_ready,
    output reg [AW-1:0] mem_src_addr,
    output reg [AW-1:0] mem_dest_addr,
    output reg cmd_rejected,
    output reg busy
);
    // idle takes commands, setup picks direction, walk emits pairs
    localparam S_IDLE = 2'h0;
    localparam S_SETUP = 2'h1;
    localparam S_WALK = 2'h2;

    // clip rectangle is internal state, not readable by software
    // only reset and a clip setup command load it, and that command never walks
    reg signed [CW-1:0] clip_left;
    reg signed [CW-1:0] clip_top;
    reg signed [CW-1:0] clip_right;
    reg signed [CW-1:0] clip_bottom;
    reg [1:0] state;
    reg signed [CW-1:0] x0;
    reg signed [CW-1:0] y0;
    reg signed [CW-1:0] x1;
    reg signed [CW-1:0] y1;
    reg signed [CW-1:0] sx0;
    reg signed [CW-1:0] sy0;
    reg signed [CW-1:0] cur_x;
    reg signed [CW-1:0] cur_y;
    reg signed [CW-1:0] off_x;
    reg signed [CW-1:0] off_y;
    reg x_back;
    reg y_back;
    reg [AW-1:0] dpitch_b;
    reg [AW-1:0] spitch_b;
    reg [2:0] bpp;
    reg [AW-1:0] sbase;
    reg [AW-1:0] dbase;

    // negative source start shifts the destination start
    wire signed [CW-1:0] adj_dl = (src_left < 0) ? dest_left - src_left : dest_left;
    wire signed [CW-1:0] adj_dt = (src_top < 0) ? dest_top - src_top : dest_top;
    wire signed [CW-1:0] adj_sl = (src_left < 0) ? {CW{1'b0}} : src_left;
    wire signed [CW-1:0] adj_st = (src_top < 0) ? {CW{1'b0}} : src_top;
    wire signed [CW-1:0] src_dx = adj_sl - adj_dl;
    wire signed [CW-1:0] src_dy = adj_st - adj_dt;

    // clip with inclusive top-left and exclusive bottom-right
    wire signed [CW-1:0] c_l = (clip_en && clip_left > adj_dl) ? clip_left : adj_dl;
    wire signed [CW-1:0] c_t = (clip_en && clip_top > adj_dt) ? clip_top : adj_dt;
    wire signed [CW-1:0] c_r = (clip_en && clip_right < dest_right) ? clip_right : dest_right;
    wire signed [CW-1:0] c_b = (clip_en && clip_bottom < dest_bottom) ? clip_bottom : dest_bottom;
    // empty after adjustment or fully clipped: nothing drawn
    // raw end against adjusted start also rejects a source shifted past the end
    wire reject = (dest_right <= adj_dl) || (dest_bottom <= adj_dt) || (c_r <= c_l) || (c_b <= c_t);

    // tiled pitch is in dwords, linear in bytes
    wire [AW-1:0] dp_ext = {{(AW-CW){1'b0}}, dest_pitch};
    wire [AW-1:0] sp_ext = {{(AW-CW){1'b0}}, src_pitch};
    wire [AW-1:0] dp_bytes = (dest_tiling == `TILE_LINEAR) ? dp_ext : (dp_ext << `DW_SHIFT);
    wire [AW-1:0] sp_bytes = (src_tiling == `TILE_LINEAR) ? sp_ext : (sp_ext << `DW_SHIFT);

    // source coordinate tracks destination by a fixed offset
    wire signed [CW-1:0] src_x = cur_x + off_x;
    wire signed [CW-1:0] src_y = cur_y + off_y;
    // sign extension keeps negative coordinates legal inside the sums
    // limitation: a final address below the base wraps; software must avoid it
    wire [AW-1:0] dx_ext = {{(AW-CW){cur_x[CW-1]}}, cur_x};
    wire [AW-1:0] dy_ext = {{(AW-CW){cur_y[CW-1]}}, cur_y};
    wire [AW-1:0] sx_ext = {{(AW-CW){src_x[CW-1]}}, src_x};
    wire [AW-1:0] sy_ext = {{(AW-CW){src_y[CW-1]}}, src_y};
    wire [AW-1:0] bpp_ext = {{(AW-3){1'b0}}, bpp};
    wire [AW-1:0] d_addr = dbase + dy_ext * dpitch_b + dx_ext * bpp_ext;
    wire [AW-1:0] s_addr = sbase + sy_ext * spitch_b + sx_ext * bpp_ext;

    // walk end conditions
    // last column is end minus one since right and bottom are exclusive
    wire x_last = x_back ? (cur_x == x0) : (cur_x == x1 - 1'b1);
    wire y_last = y_back ? (cur_y == y0) : (cur_y == y1 - 1'b1);

    wire f_in_ready;
    wire f_out_valid;
    wire [2*AW-1:0] f_out_data;
    // each walk cycle offers one pair; a full fifo holds the walk in place
    wire f_push = (state == S_WALK);

    addr_fifo #(.WIDTH(2*AW), .DEPTH(`FIFO_DEPTH), .AW(3)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(f_push),
        .in_ready(f_in_ready),
        .in_data({s_addr, d_addr}),
        .out_valid(f_out_valid),
        .out_ready(!mem_valid || mem_ready),
        .out_data(f_out_data)
    );

    // output stage registered so memory side sees flop outputs
    always @(posedge clk) begin
        if (!rstn) begin
            mem_valid <= 1'b0;
            mem_src_addr <= {AW{1'b0}};
            mem_dest_addr <= {AW{1'b0}};
        end else if (!mem_valid || mem_ready) begin
            mem_valid <= f_out_valid;
            if (f_out_valid) begin
                mem_src_addr <= f_out_data[2*AW-1:AW];
                mem_dest_addr <= f_out_data[AW-1:0];
            end
        end
    end

    // command decode and pixel walk
    always @(posedge clk) begin
        if (!rstn) begin
            state <= S_IDLE;
            cmd_ready <= 1'b0;
            cmd_rejected <= 1'b0;
            busy <= 1'b0;
            clip_left <= `CLIP_RESET;
            clip_top <= `CLIP_RESET;
            clip_right <= `CLIP_RESET;
            clip_bottom <= `CLIP_RESET;
            x0 <= {CW{1'b0}};
            y0 <= {CW{1'b0}};
            x1 <= {CW{1'b0}};
            y1 <= {CW{1'b0}};
            sx0 <= {CW{1'b0}};
            sy0 <= {CW{1'b0}};
            cur_x <= {CW{1'b0}};
            cur_y <= {CW{1'b0}};
            off_x <= {CW{1'b0}};
            off_y <= {CW{1'b0}};
            x_back <= 1'b0;
            y_back <= 1'b0;
            dpitch_b <= {AW{1'b0}};
            spitch_b <= {AW{1'b0}};
            bpp <= 3'h0;
            sbase <= {AW{1'b0}};
            dbase <= {AW{1'b0}};
        end else begin
            cmd_rejected <= 1'b0;
            case (state)
                S_IDLE: begin
                    cmd_ready <= 1'b1;
                    busy <= 1'b0;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        if (cmd_op == `CMD_CLIP_SETUP) begin
                            // clip rectangle carried on the destination fields
                            clip_left <= dest_left;
                            clip_top <= dest_top;
                            clip_right <= dest_right;
                            clip_bottom <= dest_bottom;
                        end else if (reject) begin
                            cmd_rejected <= 1'b1;
                        end else begin
                            busy <= 1'b1;
                            x0 <= c_l;
                            y0 <= c_t;
                            x1 <= c_r;
                            y1 <= c_b;
                            off_x <= src_dx;
                            off_y <= src_dy;
                            sx0 <= c_l + src_dx;
                            sy0 <= c_t + src_dy;
                            dpitch_b <= dp_bytes;
                            spitch_b <= sp_bytes;
                            bpp <= bytes_per_pixel;
                            sbase <= src_base;
                            dbase <= dest_base;
                            state <= S_SETUP;
                        end
                    end
                end
                S_SETUP: begin
                    // direction needs the stored starts, hence a cycle of its own
                    // only base equality and start compare, no overlap test
                    x_back <= (sbase == dbase) && (sx0 < x0);
                    y_back <= (sbase == dbase) && (sy0 < y0);
                    cur_x <= ((sbase == dbase) && (sx0 < x0)) ? x1 - 1'b1 : x0;
                    cur_y <= ((sbase == dbase) && (sy0 < y0)) ? y1 - 1'b1 : y0;
                    state <= S_WALK;
                end
                S_WALK: begin
                    // fifo full stalls the walk
                    if (f_in_ready) begin
                        if (x_last) begin
                            cur_x <= x_back ? x1 - 1'b1 : x0;
                            if (y_last)
                                state <= S_IDLE;
                            else
                                cur_y <= y_back ? cur_y - 1'b1 : cur_y + 1'b1;
                        end else begin
                            cur_x <= x_back ? cur_x - 1'b1 : cur_x + 1'b1;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // blit_clip_address_gen

//--- blit_clip_address_gen_bench.sv
// bench: table of rectangle commands against the clip address front end
// assumes the design, mem_partner and the bound checker are compiled first
`timescale 1ns/10ps
module blit_clip_address_gen_bench;
    typedef struct packed {int op, ce, dl, dt, dr, db, sl, st, same, tl, px;} row_t;
    row_t cur, rows[13];
    reg clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, slow = 1'b0;
    int failures, checks_done, rej_seen, rej0, clip[4];
    logic [31:0] exp_s[$], exp_d[$], exp_rej;
    wire cmd_ready, mem_valid, mem_ready, cmd_rejected, busy;
    wire [31:0] mem_src_addr, mem_dest_addr;
    // fields follow the current row; pitch 128 means bytes or dwords by tiling
    wire [1:0] cmd_op = cur.op[1:0], dest_tiling = cur.tl[1:0], src_tiling = cur.tl[1:0] ^ 2'h3;
    wire clip_en = cur.ce[0];
    wire signed [15:0] dest_left = 16'(cur.dl), dest_top = 16'(cur.dt), dest_right = 16'(cur.dr);
    wire signed [15:0] dest_bottom = 16'(cur.db), src_left = 16'(cur.sl), src_top = 16'(cur.st);
    wire [15:0] dest_pitch = 16'h0080, src_pitch = 16'h0080;
    wire [31:0] dest_base = 32'h0010_0000, src_base = cur.same ? 32'h0010_0000 : 32'h0020_0000;
    wire [2:0] bytes_per_pixel = cur.tl[0] ? 3'h2 : 3'h4;
    blit_clip_address_gen DUT (.*);
    mem_partner mdl (.*);
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) rej_seen <= rej_seen + (cmd_rejected === 1'b1);
    task check(input logic [31:0] got, want);
        checks_done++;
        if (got !== want) failures++;
        if (got !== want) $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    endtask
    task issue(input row_t r);
        for (int n = 0; n < 200 && cmd_ready !== 1'b1; n++) @(posedge clk);
        @(posedge clk);
        cur <= r;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    // expected pairs in walk order, worked out from the coordinates
    task automatic build(input row_t r);
        int l, t, rr, b, sx, sy, x, y, bp;
        bp = r.tl % 2 != 0 ? 2 : 4;
        sx = r.sl < 0 ? 0 : r.sl;
        sy = r.st < 0 ? 0 : r.st;
        l = r.sl < 0 ? r.dl - r.sl : r.dl;
        t = r.st < 0 ? r.dt - r.st : r.dt;
        rr = r.ce != 0 && r.dr > clip[2] ? clip[2] : r.dr;
        b = r.ce != 0 && r.db > clip[3] ? clip[3] : r.db;
        sx = r.ce != 0 && l < clip[0] ? sx + clip[0] - l : sx;
        sy = r.ce != 0 && t < clip[1] ? sy + clip[1] - t : sy;
        l = r.ce != 0 && l < clip[0] ? clip[0] : l;
        t = r.ce != 0 && t < clip[1] ? clip[1] : t;
        // a single command source owns the one clip set
        if (r.op == 1) clip = '{r.dl, r.dt, r.dr, r.db};
        exp_rej = r.op != 1 && (rr <= l || b <= t);
        b = r.op == 1 ? t : b;
        exp_s.delete();
        exp_d.delete();
        rej0 = rej_seen;
        for (int j = 0; j < b - t; j++) begin
            for (int i = 0; i < rr - l; i++) begin
                y = r.same != 0 && r.st < r.dt ? b - 1 - j : t + j;
                x = r.same != 0 && r.sl < r.dl ? rr - 1 - i : l + i;
                exp_d.push_back(32'h0010_0000 + y * (r.tl == 0 ? 128 : 512) + x * bp);
                exp_s.push_back(src_base_of(r) + (sy + y - t) * (r.tl == 3 ? 128 : 512) + (sx + x - l) * bp);
            end
        end
    endtask
    function automatic logic [31:0] src_base_of(input row_t r);
        return r.same != 0 ? 32'h0010_0000 : 32'h0020_0000;
    endfunction
    task settle(input int n);
        int q;
        q = 0;
        for (int n = 0; n < 3000 && q < 4; n++) begin
            @(posedge clk);
            #1;
            q = busy === 1'b0 && mem_valid === 1'b0 && cmd_ready === 1'b1 ? q + 1 : 0;
        end
        check(q >= 4, 1'b1);
        check(mdl.dest_q.size(), n);
        check(mdl.dest_q.size(), exp_d.size());
        check(rej_seen - rej0, exp_rej);
        foreach (exp_d[i]) check(mdl.dest_q[i], exp_d[i]);
        foreach (exp_s[i]) check(mdl.src_q[i], exp_s[i]);
        mdl.dest_q.delete();
        mdl.src_q.delete();
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog: whole table takes a few hundred cycles
    initial begin
        repeat (30000) @(posedge clk);
        $display("CHECK FAILED %0t watchdog expired", $time);
        failures++;
        end_of_test;
    end
    // table run, then reset in mid walk with the clip back at zero
    initial begin
        // last field: pixel pairs the row should produce
        rows = '{'{1, 0, 2, 1, 6, 5, 0, 0, 0, 0, 0}, '{0, 0, 1, 1, 3, 3, 4, 2, 0, 0, 4},
            '{0, 0, 0, 0, 2, 2, 0, 0, 0, 1, 4}, '{2, 0, 3, 2, 5, 3, 1, 1, 0, 2, 2},
            '{0, 0, 0, 0, 1, 2, 0, 0, 0, 3, 2}, '{0, 0, 1, 1, 3, 5, -1, -2, 0, 0, 2},
            '{0, 1, -2, 0, 4, 8, 0, 0, 0, 0, 8}, '{0, 0, 4, 4, 6, 6, 1, 2, 1, 0, 4},
            '{0, 0, 1, 1, 3, 2, 5, 5, 1, 0, 2}, '{0, 0, 2, 3, 4, 5, 3, 0, 1, 0, 4},
            '{0, 0, 3, 3, 3, 5, 0, 0, 0, 0, 0}, '{0, 0, 0, 0, 5, 3, 0, 0, 0, 0, 15},
            '{0, 1, 7, 0, 9, 3, 0, 0, 0, 0, 0}};
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int k = 0; k < 13; k++) begin
            slow <= k[0];
            build(rows[k]);
            issue(rows[k]);
            settle(rows[k].px);
            $display("test %0d done", k);
        end
        slow <= 1'b1;
        issue(rows[11]);
        repeat (6) @(posedge clk);
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check(mem_valid, 1'b0);
        check(busy, 1'b0);
        @(posedge clk);
        rstn <= 1'b1;
        mdl.dest_q.delete();
        mdl.src_q.delete();
        clip = '{0, 0, 0, 0};
        build(rows[6]);
        issue(rows[6]);
        settle(0);
        $display("reset test done");
        end_of_test;
    end
endmodule // blit_clip_address_gen_bench

//--- blit_clip_address_gen_properties.sv
// checker: port assertions for the blit clip address front end
// assumes one clock and rstn synchronous active low; bound below
`timescale 1ns/10ps
`include "blit_clip_map.vh"
module blit_clip_checker #(parameter CW = 16, parameter AW = 32) (
    input wire clk,
    input wire rstn,
    input wire cmd_valid,
    input wire cmd_ready,
    input wire [1:0] cmd_op,
    input wire clip_en,
    input wire signed [CW-1:0] dest_left,
    input wire signed [CW-1:0] dest_top,
    input wire signed [CW-1:0] dest_right,
    input wire signed [CW-1:0] dest_bottom,
    input wire signed [CW-1:0] src_left,
    input wire signed [CW-1:0] src_top,
    input wire mem_valid,
    input wire mem_ready,
    input wire [AW-1:0] mem_src_addr,
    input wire [AW-1:0] mem_dest_addr,
    input wire cmd_rejected,
    input wire busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // taken commands; clip setup never walks
    wire take = cmd_valid && cmd_ready;
    wire rect = take && cmd_op != `CMD_CLIP_SETUP;
    wire empty = dest_right <= dest_left || dest_bottom <= dest_top;
    AST_RESET_QUIET: assert property ($rose(rstn) |-> !cmd_ready && !mem_valid && !busy ##[1:2] cmd_ready)
        else $error("not quiet after reset");
    AST_EMPTY_REJECT: assert property (rect && empty && !mem_valid |=> cmd_rejected ##1 !mem_valid [*3])
        else $error("empty rect not rejected");
    AST_REJECT_PULSE: assert property (cmd_rejected |=> !cmd_rejected)
        else $error("reject pulse too long");
    AST_READY_DROP: assert property (take |=> !cmd_ready)
        else $error("ready stayed up");
    AST_SETUP_SILENT: assert property (take && cmd_op == `CMD_CLIP_SETUP |=> !busy && !cmd_rejected)
        else $error("clip setup walked");
    AST_WALK_START: assert property (rect && !clip_en && !empty && src_left >= 0 && src_top >= 0
        |=> busy && !cmd_rejected ##[1:6] mem_valid) else $error("walk did not start");
    AST_HOLD: assert property (mem_valid && !mem_ready |=> mem_valid && $stable({mem_src_addr, mem_dest_addr}))
        else $error("pair not held");
    AST_BUSY_NOT_READY: assert property (busy |-> !cmd_ready)
        else $error("ready while busy");
endmodule // blit_clip_checker
bind blit_clip_address_gen blit_clip_checker #(.CW(CW), .AW(AW)) chk (.*);

//--- blit_clip_map.vh
// blit_clip_map.vh: constants for the blit clip and address front end
// assumes inclusion by the design and the checker; definitions, no logic
`ifndef BLIT_CLIP_MAP_VH
`define BLIT_CLIP_MAP_VH

// ----------------------------------------------------------------
// command and tiling encodings
// ----------------------------------------------------------------
`define CMD_RECT 2'h0
`define CMD_CLIP_SETUP 2'h1
`define CMD_PIXEL 2'h2
`define TILE_LINEAR 2'h0
`define TILE_X 2'h1
`define TILE_Y 2'h2
`define LARGE_Y_TILING 2'h3

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DW_SHIFT 2
`define FIFO_DEPTH 8
`define CLIP_RESET 16'h0000

`endif

//--- mem_partner.sv
// partner: memory side accepting address pairs, prompt or slow
// assumes the design clock; slow lowers ready three cycles in four
`timescale 1ns/10ps
module mem_partner (
    input wire clk,
    input wire rstn,
    input wire slow,
    input wire mem_valid,
    output reg mem_ready = 1'b0,
    input wire [31:0] mem_src_addr,
    input wire [31:0] mem_dest_addr
);
    reg [1:0] phase = 2'h0;
    logic [31:0] src_q[$], dest_q[$];
    // stall pattern lets the fifo fill; pairs logged only when taken
    always @(posedge clk) begin
        phase <= phase + 2'h1;
        mem_ready <= rstn && (!slow || phase == 2'h3);
        if (rstn && mem_valid && mem_ready) src_q.push_back(mem_src_addr);
        if (rstn && mem_valid && mem_ready) dest_q.push_back(mem_dest_addr);
    end
endmodule // mem_partner
